// file: hw/ioam_pkg.sv
// package: register map, field layout, reset values and timing constants of the own-address block
package ioam_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses, one word each)
  // ---------------------------------------------------------------
  localparam logic [11:0] OWN_ADDRESS_LOW_OFS  = 12'h000;
  localparam logic [11:0] OWN_ADDRESS_HIGH_OFS = 12'h004;
  localparam logic [11:0] CONTROL_OFS          = 12'h008;
  localparam logic [11:0] MATCH_STATUS_OFS     = 12'h00c;

  localparam logic [7:0] OWN_ADDRESS_LOW_RST  = 8'h00;
  localparam logic [7:0] OWN_ADDRESS_HIGH_RST = 8'h40;
  localparam logic [7:0] OWN_ADDRESS_HIGH_WMASK = 8'hc6;
  localparam logic [7:0] IGNORED_ADDRESS      = 8'h01;

  // field positions
  localparam int CTRL_ENABLE_BIT   = 0;
  localparam int CTRL_TEN_BIT_BIT  = 1;
  localparam int CLOCK_RANGE_LSB   = 6;
  localparam int HIGH_ADDR_LSB     = 1;
  localparam int STAT_MATCH_BIT    = 0;
  localparam int STAT_ACK_BIT      = 1;

  // ---------------------------------------------------------------
  // timing: bus hold delay sized from the clock-range field
  // ---------------------------------------------------------------
  localparam int CORE_CLK_HZ       = 10_000_000;
  localparam int HOLD_TIME_NS      = 300;
  // cycles assumed per clock-range code, computed at the top of bands 00 and 01 and at the core clock for the other codes
  localparam int BAND0_MHZ         = 6;
  localparam int BAND1_MHZ         = 8;
  localparam int HOLD_CYC_BAND0    = (HOLD_TIME_NS * BAND0_MHZ + 999) / 1000;
  localparam int HOLD_CYC_BAND1    = (HOLD_TIME_NS * BAND1_MHZ + 999) / 1000;
  localparam int HOLD_CYC_DEFAULT  = (HOLD_TIME_NS * (CORE_CLK_HZ / 1_000_000) + 999) / 1000;

  typedef enum logic [1:0] {
    IOAM_RANGE_LT6  = 2'b00,
    IOAM_RANGE_6TO8 = 2'b01,
    IOAM_RANGE_R2   = 2'b10,
    IOAM_RANGE_R3   = 2'b11
  } ioam_range_t;

  // received address as presented by the serial front end
  typedef struct packed {
    logic       valid;
    logic       ten_bit;
    logic [9:0] addr;
  } ioam_rx_addr_t;

endpackage

// file: hw/ioam_top.sv
// own-address registers, address comparator and hold-delay timer of the two-wire slave
`timescale 1ns/1ps
// How it works
// - in 7-bit mode bits 7:1 of the low register are the slave address.
// - in 7-bit mode bit 0 of the low register is ignored and either direction bit is acked.
// - in 7-bit mode an own address of 01h is never answered.
// - disabling the interface leaves both address registers untouched.
// - in 10-bit mode all eight low register bits are the low address bits.
// - in 10-bit mode bits 2:1 of the high register are address bits 9:8.
// - the hold delay is sized from the clock-range field (00 below 6 MHz, 01 for 6-8 MHz).
// - after reset the low register reads 00h and the high register 40h.
module ioam_top
  import ioam_pkg::*;
(
  input  wire logic          i_core_clk,
  input  wire logic          i_rstn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire ioam_rx_addr_t i_rx_addr,
  output logic               o_addr_ack,
  output logic               o_addr_match,
  output logic               o_hold_busy,
  output logic               o_interface_enable
);

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic rst_meta_r;
  logic rst_sync_r;
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end
  wire logic rstn = rst_sync_r;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0] own_address_low_r;
  logic [7:0] own_address_high_r;
  logic       interface_enable_r;
  logic       ten_bit_r;
  logic       ack_seen_r;

  wire logic acc_phase = psel & penable;
  wire logic wr_en     = acc_phase & pwrite;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    return a == ofs;
  endfunction

  // enable clear has no effect here: address bits only change on writes
  always_ff @(posedge i_core_clk or negedge rstn) begin
    if (!rstn) begin
      own_address_low_r <= OWN_ADDRESS_LOW_RST;
    end else if (wr_en && hit(paddr, OWN_ADDRESS_LOW_OFS)) begin
      own_address_low_r <= pwdata[7:0];
    end
  end

  // clock-range bits only taken while disabled; address bits any time
  always_ff @(posedge i_core_clk or negedge rstn) begin
    if (!rstn) begin
      own_address_high_r <= OWN_ADDRESS_HIGH_RST;
    end else if (wr_en && hit(paddr, OWN_ADDRESS_HIGH_OFS)) begin
      own_address_high_r[HIGH_ADDR_LSB +: 2] <= pwdata[HIGH_ADDR_LSB +: 2];
      if (!interface_enable_r) begin
        own_address_high_r[CLOCK_RANGE_LSB +: 2] <= pwdata[CLOCK_RANGE_LSB +: 2];
      end
      own_address_high_r[5:3] <= 3'h0;
      own_address_high_r[0]   <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or negedge rstn) begin
    if (!rstn) begin
      interface_enable_r <= 1'b0;
      ten_bit_r          <= 1'b0;
    end else if (wr_en && hit(paddr, CONTROL_OFS)) begin
      interface_enable_r <= pwdata[CTRL_ENABLE_BIT];
      ten_bit_r          <= pwdata[CTRL_TEN_BIT_BIT];
    end
  end

  // ---------------------------------------------------------------
  // address comparator
  // ---------------------------------------------------------------
  logic match_nxt;
  always_comb begin
    match_nxt = 1'b0;
    if (interface_enable_r && i_rx_addr.valid && (i_rx_addr.ten_bit == ten_bit_r)) begin
      if (ten_bit_r) begin
        match_nxt = (i_rx_addr.addr[7:0] == own_address_low_r) &&
                    (i_rx_addr.addr[9:8] == own_address_high_r[HIGH_ADDR_LSB +: 2]);
      end else begin
        match_nxt = (i_rx_addr.addr[7:1] == own_address_low_r[7:1]) &&
                    (own_address_low_r != IGNORED_ADDRESS);
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge rstn) begin
    if (!rstn) begin
      o_addr_match <= 1'b0;
      o_addr_ack   <= 1'b0;
    end else begin
      o_addr_match <= match_nxt;
      o_addr_ack   <= match_nxt;
    end
  end

  // sticky match flag; a new match wins over the software clear
  always_ff @(posedge i_core_clk or negedge rstn) begin
    if (!rstn) begin
      ack_seen_r <= 1'b0;
    end else if (match_nxt) begin
      ack_seen_r <= 1'b1;
    end else if (wr_en && hit(paddr, MATCH_STATUS_OFS) && pwdata[STAT_ACK_BIT]) begin
      ack_seen_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // hold delay after each acknowledge
  // ---------------------------------------------------------------
  function automatic logic [3:0] hold_cycles(input logic [1:0] code);
    case (code)
      IOAM_RANGE_LT6:  return 4'(HOLD_CYC_BAND0);
      IOAM_RANGE_6TO8: return 4'(HOLD_CYC_BAND1);
      default:         return 4'(HOLD_CYC_DEFAULT);
    endcase
  endfunction

  logic [3:0] hold_cnt_r;
  always_ff @(posedge i_core_clk or negedge rstn) begin
    if (!rstn) begin
      hold_cnt_r  <= 4'h0;
      o_hold_busy <= 1'b0;
    end else if (match_nxt) begin
      hold_cnt_r  <= hold_cycles(own_address_high_r[CLOCK_RANGE_LSB +: 2]);
      o_hold_busy <= 1'b1;
    end else if (hold_cnt_r > 4'h1) begin
      hold_cnt_r  <= hold_cnt_r - 4'h1;
    end else begin
      hold_cnt_r  <= 4'h0;
      o_hold_busy <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or negedge rstn) begin
    if (!rstn) begin
      o_interface_enable <= 1'b0;
    end else begin
      o_interface_enable <= interface_enable_r;
    end
  end

  // ---------------------------------------------------------------
  // apb read side; no wait state, read data registered in the setup cycle
  // ---------------------------------------------------------------
  logic [31:0] rdata_nxt;
  logic        known;
  always_comb begin
    rdata_nxt = 32'h0;
    known     = 1'b1;
    case (paddr)
      OWN_ADDRESS_LOW_OFS:  rdata_nxt = {24'h0, own_address_low_r};
      OWN_ADDRESS_HIGH_OFS: rdata_nxt = {24'h0, own_address_high_r};
      CONTROL_OFS:          rdata_nxt = {30'h0, ten_bit_r, interface_enable_r};
      MATCH_STATUS_OFS:     rdata_nxt = {29'h0, o_hold_busy, ack_seen_r, o_addr_match};
      default:              known     = 1'b0;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge rstn) begin
    if (!rstn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~known;
      if (psel && !penable && !pwrite) begin
        prdata <= rdata_nxt;
      end
    end
  end

endmodule

// file: tb/i2c_own_address_match_bench.sv
// bench: drives the own-address block over APB and the address port against a model
`timescale 1ns/1ps
module i2c_own_address_match_bench;
  import ioam_pkg::*;
  logic          i_core_clk = 0, i_rstn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0]   paddr = '0;
  logic [31:0]   pwdata = '0, prdata;
  logic          pready, pslverr, o_addr_ack, o_addr_match, o_hold_busy, o_interface_enable;
  ioam_rx_addr_t i_rx_addr;
  int            failures = 0, tests_run = 0, seed = 32'h6713, n;
  logic [7:0]    lo = 8'h00, hi = 8'h40, v;
  logic          en = 0, ten = 0, e, seen = 0;
  always #50 i_core_clk = ~i_core_clk;
  ioam_top i_ioam_top (.*);
  ioam_i2c_master i_ioam_i2c_master (.i_clk(i_core_clk), .o_rx(i_rx_addr));
  task automatic chk(string s, logic [31:0] x, logic [31:0] g);
    tests_run++;
    if (g !== x) begin
      failures++;
      $display("BAD %s expected %h seen %h", s, x, g);
    end
  endtask
  task automatic xfer(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge i_core_clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge i_core_clk);
    penable <= 1;
    do @(posedge i_core_clk); while (pready !== 1'b1);
    {psel, penable} <= 2'b00;
  endtask
  task automatic wr(logic [11:0] a, logic [7:0] d);
    xfer(1, a, {24'h0, d});
    if (a == OWN_ADDRESS_LOW_OFS) lo = d;
    if (a == OWN_ADDRESS_HIGH_OFS) hi = en ? {hi[7:6], d[5:0] & 6'h06} : d & 8'hc6;
    if (a == CONTROL_OFS) {ten, en} = d[1:0];
    if (a == MATCH_STATUS_OFS && d[1]) seen = 0;
  endtask
  task automatic rd(logic [11:0] a);
    xfer(0, a, 32'h0);
    v = a == OWN_ADDRESS_LOW_OFS ? lo : a == OWN_ADDRESS_HIGH_OFS ? hi
      : a == CONTROL_OFS ? {6'h0, ten, en}
      : a == MATCH_STATUS_OFS ? {6'h0, seen, 1'b0} : 8'h00;
    chk("prdata", {24'h0, v}, prdata);
    chk("pslverr", a > MATCH_STATUS_OFS, pslverr);
  endtask
  task automatic hit(logic t, logic [9:0] a);
    e = en && t == ten && (ten ? a == {hi[2:1], lo} : a[7:1] == lo[7:1] && lo != 8'h01);
    i_ioam_i2c_master.send(t, a);
    seen = seen | e;
    #1 chk("ack", e, o_addr_ack);
    chk("match", e, o_addr_match);
    chk("enable", en, o_interface_enable);
    @(posedge i_core_clk);
    #1 chk("ack pulse", 1'b0, o_addr_ack);
    repeat (4) @(posedge i_core_clk);
  endtask
  task automatic hold(logic [1:0] fr, int x);
    wr(CONTROL_OFS, 0);
    wr(OWN_ADDRESS_HIGH_OFS, {fr, 6'h0});
    wr(CONTROL_OFS, 1);
    i_ioam_i2c_master.send(0, {2'b0, lo});
    seen = 1;
    n = 0;
    #1 while (o_hold_busy === 1'b1 && n < 20) begin
      n++;
      @(posedge i_core_clk);
      #1;
    end
    chk("hold", x, n);
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #5_000_000;
    failures++;
    end_sim;
  end
  initial begin
    repeat (3) @(posedge i_core_clk);
    i_rstn <= 1;
    repeat (3) @(posedge i_core_clk);
    rd(OWN_ADDRESS_LOW_OFS);
    rd(OWN_ADDRESS_HIGH_OFS);
    rd(12'h010);
    wr(OWN_ADDRESS_HIGH_OFS, 8'hff);
    rd(OWN_ADDRESS_HIGH_OFS);
    $display("test reset and reserved done");
    for (int i = 0; i < 8; i++) begin
      wr(OWN_ADDRESS_LOW_OFS, i == 0 ? 8'h01 : 8'($random(seed)));
      wr(CONTROL_OFS, 1);
      hit(0, {2'b11, lo[7:1], 1'b0});
      hit(0, {2'b00, lo[7:1], 1'b1});
      hit(0, {2'b00, lo ^ 8'h40});
      hit(1, {hi[2:1], lo});
    end
    $display("test seven bit done");
    wr(CONTROL_OFS, 3);
    for (int i = 0; i < 4; i++) begin
      wr(OWN_ADDRESS_HIGH_OFS, 8'($random(seed)));
      wr(OWN_ADDRESS_LOW_OFS, 8'($random(seed)));
      rd(OWN_ADDRESS_HIGH_OFS);
      hit(1, {hi[2:1], lo});
      hit(1, {~hi[2], hi[1], lo});
      hit(0, {hi[2:1], lo});
    end
    $display("test ten bit done");
    wr(CONTROL_OFS, 0);
    rd(OWN_ADDRESS_LOW_OFS);
    rd(OWN_ADDRESS_HIGH_OFS);
    hit(1, {hi[2:1], lo});
    $display("test disable done");
    wr(OWN_ADDRESS_LOW_OFS, 8'h5a);
    hold(2'b00, 2);
    hold(2'b01, 3);
    $display("test clock range done");
    rd(MATCH_STATUS_OFS);
    wr(MATCH_STATUS_OFS, 8'h02);
    rd(MATCH_STATUS_OFS);
    $display("test match status done");
    end_sim;
  end
endmodule

// file: tb/ioam_i2c_master.sv
// partner: bus master side, hands each heard address over as a one-cycle pulse
`timescale 1ns/1ps
module ioam_i2c_master
  import ioam_pkg::*;
(
  input  wire logic     i_clk,
  output ioam_rx_addr_t o_rx
);
  initial o_rx = '0;
  task automatic send(input logic t, input logic [9:0] a);
    @(posedge i_clk);
    o_rx <= '{1'b1, t, a};
    // stale address inverted so it never passes for a fresh one
    @(posedge i_clk);
    o_rx <= '{1'b0, ~t, ~a};
  endtask
endmodule

// file: tb/ioam_props.sv
// checker: port-level properties of the own-address block
`timescale 1ns/1ps
module ioam_props
  import ioam_pkg::*;
(
  input wire logic          i_core_clk,
  input wire logic          i_rstn,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [11:0]   paddr,
  input wire logic [31:0]   pwdata,
  input wire logic [31:0]   prdata,
  input wire logic          pready,
  input wire logic          pslverr,
  input wire ioam_rx_addr_t i_rx_addr,
  input wire logic          o_addr_ack,
  input wire logic          o_addr_match,
  input wire logic          o_hold_busy,
  input wire logic          o_interface_enable
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  a_ack_needs_valid: assert property (o_addr_ack |-> $past(i_rx_addr.valid))
    else $error("ack without address");
  a_ack_with_match: assert property (o_addr_ack |-> o_addr_match)
    else $error("ack without match");
  a_busy_on_ack: assert property (o_addr_ack |-> o_hold_busy)
    else $error("no hold after ack");
  a_busy_ends: assert property ($rose(o_hold_busy) |-> ##[1:3] !o_hold_busy)
    else $error("hold too long");
  a_high_rsvd_zero: assert property (pready && !pwrite && paddr == OWN_ADDRESS_HIGH_OFS
    |-> (prdata & 32'hffffff39) == 32'h0) else $error("reserved bits set");
  a_low_upper_zero: assert property (pready && !pwrite && paddr == OWN_ADDRESS_LOW_OFS
    |-> prdata[31:8] == 24'h0) else $error("low register too wide");
  a_enable_copy: assert property (psel && penable && pwrite && paddr == CONTROL_OFS
    |-> ##2 o_interface_enable == $past(pwdata[0], 2)) else $error("enable copy wrong");
  a_unmapped_err: assert property (pready && paddr > MATCH_STATUS_OFS |-> pslverr)
    else $error("unmapped without error");
endmodule
bind ioam_top ioam_props i_ioam_props (.*);
